//--- rtl/drive_bus_master.v
// bus master that builds drive request telegrams and checks the answers
//
// The strobed register port and the register offsets were chosen for this implementation.
`timescale 1ns/1ps
`include "telegram_defines.vh"
// Operation
// - parameter length 0, 3, 4 or 127
// - each element is one 11-bit character
// - gap before every telegram
// - telegram opens with start character 02
// - length byte = data + address + check
// - address bit 7 marks special telegram
// - broadcast bit always sent as zero
// - parameter words precede process words
// - length zero carries no parameter words
// - fixed four always sends four words
// - variable length sends only needed words
// - process words 0..8, default two
// - values right-aligned, unused words zero
// - bit 11 of first parameter word zero
// - word layout: id, number, index
// - five-bit station address, match required
// - request id encodings 0..9
module drive_bus_master #(
  parameter BIT_CYCLES = `CLK_HZ / `BAUD_DEFAULT, // clocks per serial bit
  parameter GAP_CYCLES = `GAP_CHARS * `CHAR_BITS * BIT_CYCLES, // idle before send
  parameter WAIT_CYCLES = `RESP_WAIT_CHARS * `CHAR_BITS * BIT_CYCLES // answer limit
) (
  input wire mclk_i,
  input wire rst_i,
  input wire [7:0] addr_i,
  input wire [31:0] wdata_i,
  input wire wr_i,
  input wire rd_i,
  output wire [31:0] rdata_o,
  input wire line_i,
  output wire line_o,
  output wire line_oe_o,
  output wire busy_o
);
  // ==============================
  // states and constants
  localparam [2:0] ST_IDLE = 3'h0;
  localparam [2:0] ST_GAP = 3'h1;
  localparam [2:0] ST_TX = 3'h2;
  localparam [2:0] ST_TXW = 3'h3;
  localparam [2:0] ST_RXW = 3'h4;
  localparam [2:0] ST_RX = 3'h5;
  localparam [31:0] GAP_C = GAP_CYCLES;
  localparam [31:0] WAIT_C = WAIT_CYCLES;

  reg [2:0] state_ff;
  reg [31:0] tmr_ff; // gap and answer timer
  reg [5:0] idx_ff; // byte index within telegram
  reg [7:0] bcc_ff; // running XOR
  reg [2:0] npkw_ff; // parameter words of this telegram
  reg [3:0] npzd_ff; // process words of this telegram
  reg mirror_ff;
  reg special_ff;
  reg [3:0] pzd_set_ff; // process_word_count_setting
  reg [6:0] pkw_set_ff; // param_word_count_setting
  reg [4:0] adr_ff; // station address
  reg [2:0] varlen_ff; // words needed in variable mode
  reg done_ff;
  reg ok_ff;
  reg noresp_ff;
  reg rxerr_ff;
  reg cfgerr_ff;
  reg [15:0] errcnt_ff; // rejected answers
  reg [7:0] rx_lge_ff; // received length byte
  reg [7:0] rx_hi_ff; // high byte awaiting its low byte
  reg [31:0] rdata_ff;
  reg [15:0] txbuf_ff [0:11]; // 0..3 parameter, 4..11 process
  reg [15:0] rxbuf_ff [0:15]; // answer words in arrival order

  wire tx_busy;
  wire rx_valid;
  wire [7:0] rx_byte;
  wire rx_err;
  reg [7:0] tx_byte;
  reg [15:0] tx_word;
  wire [5:0] j = idx_ff - 6'h03;
  wire [4:0] k = j[5:1];
  wire [3:0] wsum = {1'b0, npkw_ff} + npzd_ff;
  wire [7:0] telegram_length_byte = {3'h0, wsum, 1'b0} + 8'h02;
  wire [5:0] last_idx = telegram_length_byte[5:0] + 6'h01; // index of check byte
  wire [7:0] adr_byte = {special_ff, mirror_ff, 1'b0, adr_ff};
  wire go = wr_i && (addr_i == `OFS_CTRL) && wdata_i[`CTRL_GO];
  wire st_wr = wr_i && (addr_i == `OFS_STATUS);
  wire [5:0] rx_idx = idx_ff;
  wire [4:0] rk = j[5:1];

  // ==============================
  // word count of parameter channel for a setting
  function [2:0] pkw_words;
    input [6:0] set;
    input [2:0] vlen;
    begin
      case (set)
        7'h00: pkw_words = 3'h0;
        7'h03: pkw_words = 3'h3;
        7'h04: pkw_words = 3'h4;
        `PKW_VAR: pkw_words = (vlen > `PKW_MAX) ? `PKW_MAX : vlen;
        default: pkw_words = 3'h0;
      endcase
    end
  endfunction

  // legal parameter length setting
  function pkw_legal;
    input [6:0] set;
    begin
      pkw_legal = (set == 7'h00) || (set == 7'h03) || (set == 7'h04) ||
        (set == `PKW_VAR);
    end
  endfunction

  // ==============================
  // outgoing byte selection
  always @* begin
    // parameter words first, then process words
    if ({2'h0, npkw_ff} > k) begin
      tx_word = txbuf_ff[k[3:0]];
    end else begin
      tx_word = txbuf_ff[4'h4 + k[3:0] - {1'b0, npkw_ff}];
    end
    if (k == 5'h0 && npkw_ff != 3'h0) begin
      tx_word[`PKE_RSVD] = 1'b0;
    end
    if (idx_ff == 6'h00) begin
      tx_byte = `START_CHAR;
    end else if (idx_ff == 6'h01) begin
      tx_byte = telegram_length_byte;
    end else if (idx_ff == 6'h02) begin
      tx_byte = adr_byte;
    end else if (idx_ff == last_idx) begin
      tx_byte = bcc_ff;
    end else if (j[0] == 1'b0) begin
      tx_byte = tx_word[15:8];
    end else begin
      tx_byte = tx_word[7:0];
    end
  end

  // ==============================
  // serial character engine
  char_serdes #(
    .BIT_CYCLES(BIT_CYCLES)
  ) u_serdes (
    .mclk_i(mclk_i),
    .rst_i(rst_i),
    .tx_start_i(state_ff == ST_TX),
    .tx_byte_i(tx_byte),
    .tx_busy_o(tx_busy),
    .rx_en_i((state_ff == ST_RXW) || (state_ff == ST_RX)),
    .line_i(line_i),
    .line_o(line_o),
    .line_oe_o(line_oe_o),
    .rx_valid_o(rx_valid),
    .rx_byte_o(rx_byte),
    .rx_err_o(rx_err)
  );

  assign busy_o = (state_ff != ST_IDLE);
  assign rdata_o = rdata_ff;

  // ==============================
  // transmit word buffer written by software
  always @(posedge mclk_i) begin
    if (wr_i && addr_i[7:6] == `SEL_TXBUF && addr_i[5:2] < 4'hC) begin
      txbuf_ff[addr_i[5:2]] <= wdata_i[15:0];
    end
  end

  // ==============================
  // telegram sequencer and control registers
  always @(posedge mclk_i) begin
    if (rst_i) begin
      state_ff <= ST_IDLE;
      tmr_ff <= 32'h0;
      idx_ff <= 6'h0;
      bcc_ff <= 8'h0;
      npkw_ff <= 3'h0;
      npzd_ff <= 4'h0;
      mirror_ff <= 1'b0;
      special_ff <= 1'b0;
      pzd_set_ff <= `PZD_RESET;
      pkw_set_ff <= `PKW_RESET;
      adr_ff <= 5'h0;
      varlen_ff <= 3'h0;
      done_ff <= 1'b0;
      ok_ff <= 1'b0;
      noresp_ff <= 1'b0;
      rxerr_ff <= 1'b0;
      cfgerr_ff <= 1'b0;
      errcnt_ff <= 16'h0;
      rx_lge_ff <= 8'h0;
      rx_hi_ff <= 8'h0;
    end else begin
      // configuration is only taken while idle
      if (wr_i && state_ff == ST_IDLE) begin
        if (addr_i == `OFS_CTRL) begin
          mirror_ff <= wdata_i[`CTRL_MIRROR];
          special_ff <= wdata_i[`CTRL_SPECIAL];
        end
        if (addr_i == `OFS_CONFIG) begin
          pzd_set_ff <= wdata_i[`CFG_PZD_LSB +: 4];
          pkw_set_ff <= wdata_i[`CFG_PKW_LSB +: 7];
          adr_ff <= wdata_i[`CFG_ADR_LSB +: 5];
        end
        if (addr_i == `OFS_VARLEN) begin
          varlen_ff <= wdata_i[2:0];
        end
      end
      // write-one-to-clear; sets below win in the same cycle
      if (st_wr) begin
        if (wdata_i[`ST_DONE]) done_ff <= 1'b0;
        if (wdata_i[`ST_OK]) ok_ff <= 1'b0;
        if (wdata_i[`ST_NORESP]) noresp_ff <= 1'b0;
        if (wdata_i[`ST_RXERR]) rxerr_ff <= 1'b0;
        if (wdata_i[`ST_CFGERR]) cfgerr_ff <= 1'b0;
      end
      case (state_ff)
        ST_IDLE: begin
          if (go) begin
            if (pkw_legal(pkw_set_ff) && pzd_set_ff <= `PZD_MAX) begin
              npkw_ff <= pkw_words(pkw_set_ff, varlen_ff);
              npzd_ff <= pzd_set_ff;
              tmr_ff <= GAP_C;
              state_ff <= ST_GAP;
            end else begin
              cfgerr_ff <= 1'b1;
            end
          end
        end
        ST_GAP: begin
          // quiet line before the start character
          if (tmr_ff == 32'h0) begin
            idx_ff <= 6'h0;
            state_ff <= ST_TX;
          end else begin
            tmr_ff <= tmr_ff - 32'h1;
          end
        end
        ST_TX: begin
          // check byte covers every byte but itself
          if (idx_ff == 6'h00) begin
            bcc_ff <= tx_byte;
          end else if (idx_ff != last_idx) begin
            bcc_ff <= bcc_ff ^ tx_byte;
          end
          state_ff <= ST_TXW;
        end
        ST_TXW: begin
          if (!tx_busy) begin
            if (idx_ff == last_idx) begin
              tmr_ff <= WAIT_C;
              state_ff <= ST_RXW;
            end else begin
              idx_ff <= idx_ff + 6'h01;
              state_ff <= ST_TX;
            end
          end
        end
        ST_RXW: begin
          // hunt for the start character of the answer
          if (rx_valid && !rx_err && rx_byte == `START_CHAR) begin
            idx_ff <= 6'h01;
            bcc_ff <= rx_byte;
            tmr_ff <= WAIT_C;
            state_ff <= ST_RX;
          end else if (tmr_ff == 32'h0) begin
            noresp_ff <= 1'b1;
            done_ff <= 1'b1;
            state_ff <= ST_IDLE;
          end else begin
            tmr_ff <= tmr_ff - 32'h1;
          end
        end
        ST_RX: begin
          if (rx_valid) begin
            tmr_ff <= WAIT_C;
            idx_ff <= rx_idx + 6'h01;
            bcc_ff <= bcc_ff ^ rx_byte;
            if (rx_err || (rx_idx == 6'h01 && (rx_byte < 8'h02 || rx_byte > `LGE_MAX)) ||
                (rx_idx == 6'h02 && rx_byte[4:0] != adr_ff) ||
                (rx_idx > 6'h02 && rx_idx == rx_lge_ff[5:0] + 6'h01 && rx_byte != bcc_ff)) begin
              // parity, length, address or check failure drops the answer
              rxerr_ff <= 1'b1;
              done_ff <= 1'b1;
              if (errcnt_ff != 16'hFFFF) errcnt_ff <= errcnt_ff + 16'h1;
              state_ff <= ST_IDLE;
            end else if (rx_idx == 6'h01) begin
              rx_lge_ff <= rx_byte;
            end else if (rx_idx == rx_lge_ff[5:0] + 6'h01) begin
              ok_ff <= 1'b1;
              done_ff <= 1'b1;
              state_ff <= ST_IDLE;
            end else if (rx_idx > 6'h02 && j[0] == 1'b0) begin
              rx_hi_ff <= rx_byte;
            end
          end else if (tmr_ff == 32'h0) begin
            // answer stopped short of its length
            rxerr_ff <= 1'b1;
            done_ff <= 1'b1;
            if (errcnt_ff != 16'hFFFF) errcnt_ff <= errcnt_ff + 16'h1;
            state_ff <= ST_IDLE;
          end else begin
            tmr_ff <= tmr_ff - 32'h1;
          end
        end
        default: begin
          state_ff <= ST_IDLE;
        end
      endcase
    end
  end

  // ==============================
  // answer word store
  always @(posedge mclk_i) begin
    if (state_ff == ST_RX && rx_valid && !rx_err && rx_idx > 6'h02 &&
        rx_idx != rx_lge_ff[5:0] + 6'h01 && j[0] == 1'b1) begin
      rxbuf_ff[rk[3:0]] <= {rx_hi_ff, rx_byte};
    end
  end

  // ==============================
  // read port, data in the cycle after the strobe
  always @(posedge mclk_i) begin
    if (rst_i) begin
      rdata_ff <= 32'h0;
    end else if (rd_i) begin
      if (addr_i == `OFS_CTRL) begin
        rdata_ff <= {29'h0, special_ff, mirror_ff, 1'b0};
      end else if (addr_i == `OFS_CONFIG) begin
        rdata_ff <= {11'h0, adr_ff, 1'b0, pkw_set_ff, 4'h0, pzd_set_ff};
      end else if (addr_i == `OFS_VARLEN) begin
        rdata_ff <= {29'h0, varlen_ff};
      end else if (addr_i == `OFS_STATUS) begin
        rdata_ff <= {16'h0, rx_lge_ff, 2'h0, cfgerr_ff, rxerr_ff, noresp_ff, ok_ff,
          done_ff, busy_o};
      end else if (addr_i == `OFS_ERRCNT) begin
        rdata_ff <= {16'h0, errcnt_ff};
      end else if (addr_i[7:6] == `SEL_TXBUF && addr_i[5:2] < 4'hC) begin
        rdata_ff <= {16'h0, txbuf_ff[addr_i[5:2]]};
      end else if (addr_i[7:6] == `SEL_RXBUF) begin
        rdata_ff <= {16'h0, rxbuf_ff[addr_i[5:2]]};
      end else begin
        rdata_ff <= 32'h0;
      end
    end else begin
      rdata_ff <= 32'h0;
    end
  end
endmodule // drive_bus_master

//--- rtl/telegram_defines.vh
// constants shared by the drive telegram bus master
`ifndef TELEGRAM_DEFINES_VH
`define TELEGRAM_DEFINES_VH
// ==============================
// timing
`define CLK_HZ 200000000
`define BAUD_DEFAULT 38400
`define CHAR_BITS 11
`define GAP_CHARS 2
`define RESP_WAIT_CHARS 40
// ==============================
// telegram framing
`define START_CHAR 8'h02
`define PKW_VAR 7'h7F
`define PKW_MAX 3'h4
`define PZD_MAX 4'h8
`define RX_WORDS 16
`define LGE_MAX 8'h22
`define ADR_SPECIAL 7
`define ADR_MIRROR 6
`define ADR_BCAST 5
`define PKE_RSVD 11
// ==============================
// register offsets
`define OFS_CTRL 8'h00
`define OFS_CONFIG 8'h04
`define OFS_VARLEN 8'h08
`define OFS_STATUS 8'h0C
`define OFS_ERRCNT 8'h10
`define SEL_TXBUF 2'h1
`define SEL_RXBUF 2'h2
// ==============================
// field positions and reset values
`define CTRL_GO 0
`define CTRL_MIRROR 1
`define CTRL_SPECIAL 2
`define CFG_PZD_LSB 0
`define CFG_PKW_LSB 8
`define CFG_ADR_LSB 16
`define ST_BUSY 0
`define ST_DONE 1
`define ST_OK 2
`define ST_NORESP 3
`define ST_RXERR 4
`define ST_CFGERR 5
`define ST_LGE_LSB 8
`define PZD_RESET 4'h2
`define PKW_RESET 7'h7F
`endif

//--- rtl/char_serdes.v
// one 11-bit serial character transmitter and receiver, half duplex
`timescale 1ns/1ps
`include "telegram_defines.vh"
module char_serdes #(
  parameter BIT_CYCLES = `CLK_HZ / `BAUD_DEFAULT
) (
  input wire mclk_i,
  input wire rst_i,
  input wire tx_start_i,
  input wire [7:0] tx_byte_i,
  output wire tx_busy_o,
  input wire rx_en_i,
  input wire line_i,
  output wire line_o,
  output wire line_oe_o,
  output wire rx_valid_o,
  output wire [7:0] rx_byte_o,
  output wire rx_err_o
);
  localparam [31:0] BIT_M1 = BIT_CYCLES - 1;
  localparam [31:0] HALF = BIT_CYCLES / 2;

  reg [10:0] tx_sh_ff; // start, data lsb first, parity, stop
  reg [3:0] tx_cnt_ff; // bits still to send
  reg [31:0] tx_tmr_ff;
  reg s1_ff; // synchroniser first stage
  reg s2_ff;
  reg s3_ff; // delayed copy for edge detect
  reg [10:0] rx_sh_ff;
  reg [3:0] rx_cnt_ff;
  reg [31:0] rx_tmr_ff;
  reg rx_valid_ff;

  assign tx_busy_o = (tx_cnt_ff != 4'h0);
  assign line_oe_o = tx_busy_o;
  assign line_o = tx_busy_o ? tx_sh_ff[0] : 1'b1;
  assign rx_valid_o = rx_valid_ff;
  assign rx_byte_o = rx_sh_ff[8:1];
  // bad start, missing stop or odd parity over data plus parity
  assign rx_err_o = rx_sh_ff[0] | ~rx_sh_ff[10] | (^rx_sh_ff[9:1]);

  // ==============================
  // transmit shifter
  always @(posedge mclk_i) begin
    if (rst_i) begin
      tx_sh_ff <= 11'h7FF;
      tx_cnt_ff <= 4'h0;
      tx_tmr_ff <= 32'h0;
    end else if (tx_start_i && !tx_busy_o) begin
      // even parity makes the ones count even
      tx_sh_ff <= {1'b1, ^tx_byte_i, tx_byte_i, 1'b0};
      tx_cnt_ff <= 4'hB;
      tx_tmr_ff <= BIT_M1;
    end else if (tx_busy_o) begin
      if (tx_tmr_ff == 32'h0) begin
        tx_sh_ff <= {1'b1, tx_sh_ff[10:1]};
        tx_cnt_ff <= tx_cnt_ff - 4'h1;
        tx_tmr_ff <= BIT_M1;
      end else begin
        tx_tmr_ff <= tx_tmr_ff - 32'h1;
      end
    end
  end

  // ==============================
  // receive sampler, mid-bit
  always @(posedge mclk_i) begin
    if (rst_i) begin
      s1_ff <= 1'b1;
      s2_ff <= 1'b1;
      s3_ff <= 1'b1;
      rx_sh_ff <= 11'h0;
      rx_cnt_ff <= 4'h0;
      rx_tmr_ff <= 32'h0;
      rx_valid_ff <= 1'b0;
    end else begin
      s1_ff <= line_i;
      s2_ff <= s1_ff;
      s3_ff <= s2_ff;
      rx_valid_ff <= 1'b0;
      if (rx_cnt_ff == 4'h0) begin
        // falling edge opens a character
        if (rx_en_i && s3_ff && !s2_ff) begin
          rx_cnt_ff <= 4'hB;
          rx_tmr_ff <= HALF;
        end
      end else if (rx_tmr_ff == 32'h0) begin
        rx_sh_ff <= {s2_ff, rx_sh_ff[10:1]};
        rx_cnt_ff <= rx_cnt_ff - 4'h1;
        rx_tmr_ff <= BIT_M1;
        rx_valid_ff <= (rx_cnt_ff == 4'h1);
      end else begin
        rx_tmr_ff <= rx_tmr_ff - 32'h1;
      end
    end
  end
endmodule // char_serdes

//--- bench/drive_bus_master_asserts.sv
// concurrent checks on the ports of the drive telegram bus master
`timescale 1ns/1ps
`include "telegram_defines.vh"
module drive_bus_master_asserts #(
  parameter BIT_CYCLES = 8,
  parameter GAP_CYCLES = 200,
  parameter WAIT_CYCLES = 2000
) (
  input wire mclk_i,
  input wire rst_i,
  input wire [7:0] addr_i,
  input wire [31:0] wdata_i,
  input wire wr_i,
  input wire rd_i,
  input wire [31:0] rdata_o,
  input wire line_i,
  input wire line_o,
  input wire line_oe_o,
  input wire busy_o
);
  // ==============================
  // clocking
  default clocking dc @(posedge mclk_i);
  endclocking
  default disable iff (rst_i);
  // ==============================
  // register port
  read_idle_a: assert property (
    !rd_i |=> rdata_o == 32'h0) else $error("read data not zero outside a read");
  unmapped_zero_a: assert property (
    rd_i && addr_i == 8'h3C |=> rdata_o == 32'h0) else $error("unmapped read not zero");
  word_pairs_a: assert property (
    rd_i && addr_i[7:6] != 2'h0 |=> rdata_o[31:16] == 16'h0)
    else $error("upper half of a word register not zero");
  busy_bit_a: assert property (
    rd_i && addr_i == `OFS_STATUS |=> rdata_o[`ST_BUSY] == $past(busy_o))
    else $error("status busy bit differs from busy");
  errcnt_width_a: assert property (
    rd_i && addr_i == `OFS_ERRCNT |=> rdata_o[31:16] == 16'h0)
    else $error("error count wider than 16 bits");
  // ==============================
  // serial line
  reset_idle_a: assert property (
    disable iff (1'b0) $fell(rst_i) |-> line_o && !line_oe_o && !busy_o)
    else $error("line or busy not idle after reset");
  stop_bit_a: assert property (
    $fell(line_oe_o) |-> $past(line_o)) else $error("character ends without a stop bit");
  start_bit_a: assert property (
    $rose(line_oe_o) |-> !line_o ##1 (!line_o && line_oe_o))
    else $error("character does not open with a start bit");
  quiet_gap_a: assert property (
    $rose(busy_o) |-> !line_oe_o [*8]) else $error("no gap before the telegram");
  drive_busy_a: assert property (
    line_oe_o |-> busy_o) else $error("line driven while idle");
  // main scenarios reached
  cv_frame: cover property ($rose(line_oe_o));
  cv_done: cover property ($fell(busy_o));
  cv_status: cover property (rd_i && addr_i == `OFS_STATUS);
endmodule // drive_bus_master_asserts

bind drive_bus_master drive_bus_master_asserts #(.BIT_CYCLES(BIT_CYCLES),
  .GAP_CYCLES(GAP_CYCLES), .WAIT_CYCLES(WAIT_CYCLES)) chk_i (.mclk_i(mclk_i),
  .rst_i(rst_i), .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i),
  .rdata_o(rdata_o), .line_i(line_i), .line_o(line_o), .line_oe_o(line_oe_o),
  .busy_o(busy_o));

//--- bench/drive_model.sv
// drive-side model: takes a request telegram and answers it
`timescale 1ns/1ps
module drive_model #(
  parameter BITC = 8,
  parameter STN = 5,
  parameter MON = 20000000 // bus monitoring time in clocks (100 ms), zero disables
) (
  input wire clk_i,
  input wire line_i,
  input wire bad_i,
  output logic tx_o,
  output logic oe_o
);
  logic [7:0] rxq [$]; // last request as received
  logic [7:0] f [$]; // frame being handled
  logic [7:0] b, ln, x;
  logic perr; // parity or stop fault seen
  int rx_errs = 0; // receive error statistics
  int cyc = 0; // free running clock count
  int pd_cyc = 0; // clock count when process data last arrived
  logic fault = 1'b0; // bus_timeout_fault, sticky
  // ==============================
  // bus monitoring: fault when process data stays away one whole period
  always @(posedge clk_i) begin
    cyc <= cyc + 1;
    if (MON != 0 && cyc - pd_cyc > MON) fault <= 1'b1;
  end
  // ==============================
  // receive one character, sampled mid-bit
  task automatic get_char(output logic [7:0] v);
    logic [9:0] s;
    while (line_i !== 1'b0) @(posedge clk_i);
    repeat (BITC / 2) @(posedge clk_i);
    for (int k = 0; k < 10; k++) begin
      repeat (BITC) @(posedge clk_i);
      s[k] = line_i;
    end
    v = s[7:0];
    perr = perr | (s[8] ^ (^s[7:0])) | !s[9];
  endtask
  // send one character: start, data lsb first, even parity, stop
  task automatic put_char(input logic [7:0] v);
    logic [10:0] s;
    s = {1'b1, ^v, v, 1'b0};
    for (int k = 0; k < 11; k++) begin
      tx_o <= s[k];
      repeat (BITC) @(posedge clk_i);
    end
  endtask
  // ==============================
  // frame loop
  initial begin
    tx_o = 1'b1;
    oe_o = 1'b0;
    forever begin
      perr = 1'b0;
      f.delete();
      get_char(b);
      if (b == 8'h02) begin
        f.push_back(b);
        get_char(ln);
        f.push_back(ln);
        for (int i = 0; i < ln; i++) begin
          get_char(b);
          f.push_back(b);
        end
        rxq = f;
        x = 8'h00;
        foreach (f[i]) x = x ^ f[i];
        // bad or foreign frames are dropped silently
        if (x != 8'h00 || perr) rx_errs++;
        if (x == 8'h00 && !perr && f[2][4:0] == STN) begin
          pd_cyc = cyc;
          // normal answer inverts data; an even byte count keeps the check byte
          if (!f[2][6]) begin
            for (int i = 3; i < f.size() - 1; i++) f[i] = ~f[i];
          end
          if (bad_i) begin
            f[f.size() - 1] = ~f[f.size() - 1];
          end
          repeat (60) @(posedge clk_i);
          oe_o <= 1'b1;
          foreach (f[i]) put_char(f[i]);
          oe_o <= 1'b0;
          tx_o <= 1'b1;
        end
      end
    end
  end
endmodule // drive_model

//--- bench/tb_drive_bus_master.sv
// self-checking testbench for the drive telegram bus master
`timescale 1ns/1ps
`include "telegram_defines.vh"
module tb_drive_bus_master;
  logic mclk_i = 1'b0;
  logic rst_i = 1'b1;
  logic [7:0] addr_i = 8'h00;
  logic [31:0] wdata_i = 32'h0;
  logic wr_i = 1'b0;
  logic rd_i = 1'b0;
  logic bad = 1'b0; // model corrupts its check byte
  wire [31:0] rdata_o;
  wire line_o, line_oe_o, busy_o, dev_tx, dev_oe;
  wire line_w; // resolved bus, biased high when free
  int error_cnt = 0;
  int checked = 0;
  int seed = 32'h579995BE;
  logic [15:0] txw [12];
  logic [7:0] exq [$]; // expected request frame
  logic [31:0] d;
  // pkw, varlen, pzd, ctrl, bad, station, expected status
  int tp [8][7] = '{'{127, 2, 2, 3, 0, 5, 4}, '{4, 0, 8, 5, 0, 5, 4}, '{3, 0, 0, 1, 0, 5, 4},
    '{0, 0, 1, 3, 1, 5, 16}, '{127, 4, 3, 1, 0, 6, 8}, '{5, 0, 2, 1, 0, 5, 32},
    '{0, 0, 9, 1, 0, 5, 32}, '{127, 0, 0, 3, 0, 5, 4}};
  always #2.5 mclk_i = ~mclk_i;
  assign line_w = line_oe_o ? line_o : (dev_oe ? dev_tx : 1'b1);
  drive_bus_master #(.BIT_CYCLES(8), .GAP_CYCLES(200), .WAIT_CYCLES(2000)) DUT (
    .mclk_i(mclk_i), .rst_i(rst_i), .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i),
    .rd_i(rd_i), .rdata_o(rdata_o), .line_i(line_w), .line_o(line_o),
    .line_oe_o(line_oe_o), .busy_o(busy_o));
  drive_model #(.BITC(8), .STN(5), .MON(20000)) PM (.clk_i(mclk_i), .line_i(line_w), .bad_i(bad),
    .tx_o(dev_tx), .oe_o(dev_oe));
  // ==============================
  // tasks
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    checked++;
    if (g !== e) begin
      error_cnt++;
      $display("[FAIL] t=%0t got %h exp %h", $time, g, e);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    @(posedge mclk_i);
    addr_i <= a;
    wdata_i <= v;
    wr_i <= 1'b1;
    @(posedge mclk_i);
    wr_i <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] v);
    @(posedge mclk_i);
    addr_i <= a;
    rd_i <= 1'b1;
    @(posedge mclk_i);
    rd_i <= 1'b0;
    #1 v = rdata_o;
  endtask
  task automatic results();
    $display("checked %0d mismatches %0d", checked, error_cnt);
    if (error_cnt == 0 && checked > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask
  // one telegram exchange with its expected frame and status
  task automatic run(input int pk, vl, pz, ctl, md, stn, est);
    int nw, n, i;
    logic [7:0] x;
    logic [15:0] w;
    bad <= md[0];
    wr(`OFS_CONFIG, (stn << 16) | (pk << 8) | pz);
    wr(`OFS_VARLEN, vl);
    for (i = 0; i < 12; i++) begin
      txw[i] = $random(seed);
      wr(8'(8'h40 + 4 * i), {16'h0, txw[i]});
    end
    nw = (pk == 127) ? vl : pk;
    exq = '{8'h02, 8'(2 * (nw + pz) + 2), {ctl[2:1], 1'b0, stn[4:0]}};
    for (i = 0; i < nw + pz; i++) begin
      w = txw[(i < nw) ? i : 4 + i - nw];
      if (i == 0 && nw > 0) w[11] = 1'b0;
      exq.push_back(w[15:8]);
      exq.push_back(w[7:0]);
    end
    x = 8'h00;
    foreach (exq[i]) x = x ^ exq[i];
    exq.push_back(x);
    PM.rxq.delete();
    wr(`OFS_CTRL, ctl);
    repeat (2) @(posedge mclk_i);
    n = 0;
    while (busy_o !== 1'b0 && n < 20000) begin
      @(posedge mclk_i);
      #1 n++;
    end
    if (n == 20000) begin
      error_cnt++;
      results();
    end
    rd(`OFS_STATUS, d);
    chk(d & 32'h3C, est);
    if (est == 32) exq.delete();
    chk(PM.rxq.size(), exq.size());
    foreach (exq[i]) chk(PM.rxq[i], exq[i]);
    if (est == 4) begin
      chk(d[15:8], exq[1]);
      for (i = 0; i < nw + pz; i++) begin
        rd(8'(8'h80 + 4 * i), d);
        w = {exq[3 + 2 * i], exq[4 + 2 * i]};
        w = ctl[1] ? w : ~w;
        chk(d, {16'h0, w});
      end
    end
    wr(`OFS_STATUS, 32'h3E);
  endtask
  // ==============================
  // main sequence
  initial begin
    repeat (16) @(posedge mclk_i);
    rst_i <= 1'b0;
    rd(`OFS_CONFIG, d);
    chk(d, 32'h7F02);
    rd(`OFS_ERRCNT, d);
    chk(d, 32'h0);
    rd(8'h3C, d);
    chk(d, 32'h0);
    for (int k = 0; k < 8; k++) begin
      run(tp[k][0], tp[k][1], tp[k][2], tp[k][3], tp[k][4], tp[k][5], tp[k][6]);
      $display("test %0d done", k);
    end
    rd(`OFS_ERRCNT, d);
    chk(d, 32'h1);
    chk(PM.rx_errs, 32'h0);
    chk(PM.fault, 32'h0);
    results();
  end
endmodule // tb_drive_bus_master
